/* rtl/cal_pkg.sv */
// types shared by the calibration block
package cal_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_DIV   = 3'b010,
    ST_CHECK = 3'b011,
    ST_DONE  = 3'b100
  } cal_state_t;
endpackage

/* rtl/cal_regs.svh */
// register offsets, field layout, reset values and limits of the calibration block
`ifndef CAL_REGS_SVH
`define CAL_REGS_SVH
`define CAL_CTRL_OFF      12'h000
`define CAL_STATUS_OFF    12'h004
`define CAL_GAIN_I1_OFF   12'h008
`define CAL_GAIN_I2_OFF   12'h00c
`define CAL_GAIN_V_OFF    12'h010
`define CAL_GAIN_P1_OFF   12'h014
`define CAL_GAIN_P2_OFF   12'h018
`define CAL_EXP_I_OFF     12'h01c
`define CAL_EXP_V_OFF     12'h020
`define CAL_EXP_P_OFF     12'h024
`define CAL_MEAS_I1_OFF   12'h028
`define CAL_MEAS_I2_OFF   12'h02c
`define CAL_MEAS_V_OFF    12'h030
`define CAL_MEAS_P1_OFF   12'h034
`define CAL_MEAS_P2_OFF   12'h038
`define CAL_RANGE_OFF     12'h03c
`define CAL_PHASE1_OFF    12'h040
`define CAL_PHASE2_OFF    12'h044
`define CAL_CTRL_GO_BIT   0
`define CAL_CTRL_CH1_BIT  1
`define CAL_CTRL_CH2_BIT  2
`define CAL_ST_BUSY_BIT   0
`define CAL_ST_DONE_BIT   1
`define CAL_ST_ACK_BIT    2
`define CAL_ST_NAK_BIT    3
`define CAL_GAIN_RST      16'h8000
`define CAL_RANGE_RST     5'h0c
`define CAL_GAIN_MIN      32'd25000
`define CAL_GAIN_MAX      32'd65535
`define CAL_SAMPLES_CYC   56
`define CAL_DIV_STEPS     6'd32
`endif

/* rtl/gain_divider.sv */
// sequential gain scaler: quot = gain * expected / measured, one bit per cycle
`timescale 1ns/1ps
`include "cal_regs.svh"
module gain_divider (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [15:0] gain_old,
  input  wire logic [15:0] expected,
  input  wire logic [15:0] measured,
  output logic             done,
  output logic [31:0]      quot
);
  logic [31:0] num_ff;
  logic [32:0] rem_ff;
  logic [5:0]  cnt_ff;
  logic        run_ff;
  logic [32:0] trial;

  assign trial = {rem_ff[31:0], num_ff[31]} - {17'h0, measured};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      num_ff <= 32'h0;
      rem_ff <= 33'h0;
      cnt_ff <= 6'h0;
      run_ff <= 1'b0;
      quot   <= 32'h0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        num_ff <= gain_old * expected;
        rem_ff <= 33'h0;
        cnt_ff <= `CAL_DIV_STEPS;
        run_ff <= 1'b1;
        quot   <= 32'h0;
      end else if (run_ff) begin
        // zero divisor gives all ones, which the window check rejects
        if (!trial[32]) begin
          rem_ff <= trial;
          quot   <= {quot[30:0], 1'b1};
        end else begin
          rem_ff <= {rem_ff[31:0], num_ff[31]};
          quot   <= {quot[30:0], 1'b0};
        end
        num_ff <= {num_ff[30:0], 1'b0};
        cnt_ff <= cnt_ff - 6'd1;
        if (cnt_ff == 6'd1) begin
          run_ff <= 1'b0;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule // gain_divider

/* rtl/power_monitor_gain_phase_calibration.sv */
// gain auto-calibration and phase compensation registers, apb slave
// Notes on behaviour
// - gain command updates both current gains, voltage gain, both power gains.
// - channel select bits choose channel one, two or both.
// - new gain equals old gain times expected over measured.
// - a new gain is valid only from 25000 through 65535.
// - ack when every new gain valid, nak when any is not.
// - range gives right shifts after multiply by current gain.
// - separate phase compensation per channel.
// - 56 samples per line cycle, one step is 360/56 degrees.
// - phase value signed, correcting up to half a step.
`timescale 1ns/1ps
`include "cal_regs.svh"
module power_monitor_gain_phase_calibration (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] meas_irms1,
  input  wire logic [15:0] meas_irms2,
  input  wire logic        irms_valid,
  output logic      [15:0] irms1_scaled,
  output logic      [15:0] irms2_scaled,
  output logic signed [7:0] phase_comp1,
  output logic signed [7:0] phase_comp2,
  output logic             cal_busy
);
  // ======================================================================
  // registers
  // ======================================================================
  logic [15:0] gain_ff [5];
  logic [15:0] new_ff [5];
  logic [4:0]  ok_ff;
  logic [15:0] exp_i_ff, exp_v_ff, exp_p_ff;
  logic [15:0] meas_ff [5];
  logic [4:0]  range_ff;
  logic [15:0] phase1_ff, phase2_ff;
  logic        ch1_ff, ch2_ff, done_ff, ack_ff, nak_ff;
  logic [2:0]  idx_ff;
  cal_pkg::cal_state_t state_ff;
  logic        div_start_ff, div_done;
  logic [31:0] div_quot;
  logic [15:0] cur_exp;
  logic        wr_acc, rd_acc;

  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite && pready;

  // quantity index: 0 i1, 1 i2, 2 v, 3 p1, 4 p2
  function automatic logic [15:0] exp_of(input logic [2:0] i, input logic [15:0] ei,
                                         input logic [15:0] ev, input logic [15:0] ep);
    exp_of = (i < 3'd2) ? ei : (i == 3'd2) ? ev : ep;
  endfunction

  function automatic logic sel_of(input logic [2:0] i, input logic c1, input logic c2);
    sel_of = (i == 3'd2) ? (c1 | c2) : (i == 3'd0 || i == 3'd3) ? c1 : c2;
  endfunction

  assign cur_exp = exp_of(idx_ff, exp_i_ff, exp_v_ff, exp_p_ff);

  gain_divider u_div (
    .mclk     (mclk),
    .rst      (rst),
    .start    (div_start_ff),
    .gain_old (gain_ff[idx_ff]),
    .expected (cur_exp),
    .measured (meas_ff[idx_ff]),
    .done     (div_done),
    .quot     (div_quot)
  );

  // ======================================================================
  // calibration sequencer
  // ======================================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff     <= cal_pkg::ST_IDLE;
      idx_ff       <= 3'h0;
      div_start_ff <= 1'b0;
      ok_ff        <= 5'h0;
      done_ff      <= 1'b0;
      ack_ff       <= 1'b0;
      nak_ff       <= 1'b0;
      ch1_ff       <= 1'b0;
      ch2_ff       <= 1'b0;
      cal_busy     <= 1'b0;
      for (int k = 0; k < 5; k++) begin
        new_ff[k] <= 16'h0;
      end
    end else begin
      div_start_ff <= 1'b0;
      case (state_ff)
        cal_pkg::ST_IDLE: begin
          if (wr_acc && paddr == `CAL_CTRL_OFF && pwdata[`CAL_CTRL_GO_BIT]) begin
            ch1_ff   <= pwdata[`CAL_CTRL_CH1_BIT];
            ch2_ff   <= pwdata[`CAL_CTRL_CH2_BIT];
            idx_ff   <= 3'h0;
            ok_ff    <= 5'h0;
            done_ff  <= 1'b0;
            ack_ff   <= 1'b0;
            nak_ff   <= 1'b0;
            cal_busy <= 1'b1;
            state_ff <= cal_pkg::ST_LOAD;
          end
        end
        cal_pkg::ST_LOAD: begin
          if (sel_of(idx_ff, ch1_ff, ch2_ff)) begin
            div_start_ff <= 1'b1;
            state_ff     <= cal_pkg::ST_DIV;
          end else begin
            // unselected quantity keeps its gain and counts as valid
            new_ff[idx_ff] <= gain_ff[idx_ff];
            ok_ff[idx_ff]  <= 1'b1;
            state_ff       <= cal_pkg::ST_CHECK;
          end
        end
        cal_pkg::ST_DIV: begin
          if (div_done) begin
            new_ff[idx_ff] <= div_quot[15:0];
            ok_ff[idx_ff]  <= (div_quot >= `CAL_GAIN_MIN) && (div_quot <= `CAL_GAIN_MAX);
            state_ff       <= cal_pkg::ST_CHECK;
          end
        end
        cal_pkg::ST_CHECK: begin
          if (idx_ff == 3'd4) begin
            state_ff <= cal_pkg::ST_DONE;
          end else begin
            idx_ff   <= idx_ff + 3'd1;
            state_ff <= cal_pkg::ST_LOAD;
          end
        end
        cal_pkg::ST_DONE: begin
          ack_ff   <= &ok_ff;
          nak_ff   <= ~&ok_ff;
          done_ff  <= 1'b1;
          cal_busy <= 1'b0;
          state_ff <= cal_pkg::ST_IDLE;
        end
        default: state_ff <= cal_pkg::ST_IDLE;
      endcase
    end
  end

  // ======================================================================
  // gain registers: commit only on full success
  // ======================================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 5; k++) begin
        gain_ff[k] <= `CAL_GAIN_RST;
      end
    end else if (state_ff == cal_pkg::ST_DONE && (&ok_ff)) begin
      for (int k = 0; k < 5; k++) begin
        gain_ff[k] <= new_ff[k];
      end
    end else if (wr_acc && state_ff == cal_pkg::ST_IDLE) begin
      // nak leaves gains untouched; only direct writes change them
      for (int k = 0; k < 5; k++) begin
        if (paddr == `CAL_GAIN_I1_OFF + 12'(4 * k)) begin
          gain_ff[k] <= pwdata[15:0];
        end
      end
    end
  end

  // ======================================================================
  // configuration registers
  // ======================================================================
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      exp_i_ff  <= 16'h0;
      exp_v_ff  <= 16'h0;
      exp_p_ff  <= 16'h0;
      range_ff  <= `CAL_RANGE_RST;
      phase1_ff <= 16'h0;
      phase2_ff <= 16'h0;
      for (int k = 0; k < 5; k++) begin
        meas_ff[k] <= 16'h0;
      end
    end else if (wr_acc && !cal_busy) begin
      case (paddr)
        `CAL_EXP_I_OFF:  exp_i_ff <= pwdata[15:0];
        `CAL_EXP_V_OFF:  exp_v_ff <= pwdata[15:0];
        `CAL_EXP_P_OFF:  exp_p_ff <= pwdata[15:0];
        `CAL_RANGE_OFF:  range_ff <= pwdata[4:0];
        `CAL_PHASE1_OFF: phase1_ff <= pwdata[15:0];
        `CAL_PHASE2_OFF: phase2_ff <= pwdata[15:0];
        default: begin
          for (int k = 0; k < 5; k++) begin
            if (paddr == `CAL_MEAS_I1_OFF + 12'(4 * k)) begin
              meas_ff[k] <= pwdata[15:0];
            end
          end
        end
      endcase
    end
  end

  // ======================================================================
  // current scaling and phase outputs
  // ======================================================================
  logic [31:0] prod1, prod2;
  assign prod1 = meas_irms1 * gain_ff[0];
  assign prod2 = meas_irms2 * gain_ff[1];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irms1_scaled <= 16'h0;
      irms2_scaled <= 16'h0;
      phase_comp1  <= 8'sh0;
      phase_comp2  <= 8'sh0;
    end else begin
      if (irms_valid) begin
        irms1_scaled <= 16'(prod1 >> range_ff);
        irms2_scaled <= 16'(prod2 >> range_ff);
      end
      // signed low byte, one count is 1/256 of a step
      phase_comp1 <= phase1_ff[7:0];
      phase_comp2 <= phase2_ff[7:0];
    end
  end

  // ======================================================================
  // apb slave: zero wait states, unmapped reads zero with error
  // ======================================================================
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `CAL_PHASE2_OFF);
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `CAL_STATUS_OFF: prdata <= {28'h0, nak_ff, ack_ff, done_ff, cal_busy};
          `CAL_CTRL_OFF:   prdata <= {29'h0, ch2_ff, ch1_ff, 1'b0};
          `CAL_EXP_I_OFF:  prdata <= {16'h0, exp_i_ff};
          `CAL_EXP_V_OFF:  prdata <= {16'h0, exp_v_ff};
          `CAL_EXP_P_OFF:  prdata <= {16'h0, exp_p_ff};
          `CAL_RANGE_OFF:  prdata <= {27'h0, range_ff};
          `CAL_PHASE1_OFF: prdata <= {16'h0, phase1_ff};
          `CAL_PHASE2_OFF: prdata <= {16'h0, phase2_ff};
          default: begin
            prdata <= 32'h0;
            for (int k = 0; k < 5; k++) begin
              if (paddr == `CAL_GAIN_I1_OFF + 12'(4 * k)) prdata <= {16'h0, gain_ff[k]};
              if (paddr == `CAL_MEAS_I1_OFF + 12'(4 * k)) prdata <= {16'h0, meas_ff[k]};
            end
          end
        endcase
      end else if (rd_acc) begin
        prdata <= 32'h0;
      end
    end
  end
endmodule // power_monitor_gain_phase_calibration

/* tb/cal_checker_assertions.sv */
// port assertions for the calibration block
`timescale 1ns/1ps
module cal_checker (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irms_valid,
  input wire logic [15:0]       irms1_scaled,
  input wire logic signed [7:0] phase_comp1,
  input wire logic signed [7:0] phase_comp2,
  input wire logic              cal_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr_done;
  logic wr_ph1;
  logic wr_ph2;
  assign wr_done = psel && penable && pready && pwrite;
  assign wr_ph1 = wr_done && paddr == 12'h040;
  assign wr_ph2 = wr_done && paddr == 12'h044;
  // ==========================================
  // bus timing
  a_ready_wait: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_decode: assert property (psel && !penable |=>
    pslverr == (paddr[1:0] != 2'b00 || paddr > 12'h044)) else $error("bad slave error");
  // ==========================================
  // calibration and outputs
  a_go_busy: assert property (
    wr_done && paddr == 12'h000 && pwdata[0] && |pwdata[2:1] && !cal_busy |=> cal_busy)
    else $error("command did not start");
  a_busy_bound: assert property ($rose(cal_busy) |-> ##[1:250] !cal_busy)
    else $error("command never answered");
  a_phase1_src: assert property ($changed(phase_comp1) |->
    $past(wr_ph1) || $past(wr_ph1, 2)) else $error("phase one moved alone");
  a_phase2_src: assert property ($changed(phase_comp2) |->
    $past(wr_ph2) || $past(wr_ph2, 2)) else $error("phase two moved alone");
  a_irms_src: assert property ($changed(irms1_scaled) |-> $past(irms_valid))
    else $error("scaled value without sample");
endmodule // cal_checker

/* tb/cal_host.sv */
// host model issuing apb transfers and calibration sequences
`timescale 1ns/1ps
`include "cal_regs.svh"
module cal_host (
  input  wire logic        mclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  logic [31:0] rq;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // ==========================================
  // bus cycles, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no cycle budget here: a hang is left to the bench watchdog
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next request never lands in the same step
    @(posedge mclk);
  endtask

  // frequency step and analog sources sit outside this block
  // targets and readings first, then the command
  task automatic gain_cmd(input logic [1:0] sel, input logic [15:0] x[8]);
    for (int i = 0; i < 8; i++)
      xfer(1'b1, `CAL_EXP_I_OFF + 12'(4 * i), {16'h0, x[i]}, rq);
    xfer(1'b1, `CAL_CTRL_OFF, {29'h0, sel, 1'b1}, rq);
  endtask

  // degrees to counts, signed add, low byte only
  task automatic phase_adj(input logic [11:0] a, input logic [7:0] old, input real deg);
    logic [7:0] corr;
    corr = 8'(int'(deg * 40.0));
    xfer(1'b1, a, {24'h0, old + corr}, rq);
  endtask
endmodule // cal_host

/* tb/power_monitor_gain_phase_calibration_tb.sv */
// self-checking bench for the gain and phase calibration block
`timescale 1ns/1ps
`include "cal_regs.svh"
module power_monitor_gain_phase_calibration_tb;
  logic              mclk, rst, psel, penable, pwrite, pready, pslverr, irms_valid, cal_busy;
  logic              vld_d;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rq, got;
  logic [15:0]       meas_irms1, meas_irms2, irms1_scaled, irms2_scaled;
  logic signed [7:0] phase_comp1, phase_comp2;
  logic [33:0]       exp_q[$];
  logic [33:0]       e;
  logic [15:0]       g[5];
  logic [15:0]       x[8];
  int                failures, samples_checked;
  int                eidx[5] = '{0, 0, 1, 2, 2};
  int                chn[5] = '{0, 1, 2, 0, 1};

  power_monitor_gain_phase_calibration dut_u (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas_irms1(meas_irms1), .meas_irms2(meas_irms2),
    .irms_valid(irms_valid), .irms1_scaled(irms1_scaled), .irms2_scaled(irms2_scaled),
    .phase_comp1(phase_comp1), .phase_comp2(phase_comp2), .cal_busy(cal_busy));
  cal_host host_u (.mclk(mclk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic miss(input logic [33:0] a, input logic [31:0] b);
    failures++;
    $display("MISMATCH t=%0t exp %h got %h", $time, a, b);
  endtask

  // ==========================================
  // watcher: oldest note against each answer
  always @(posedge mclk) begin
    vld_d <= irms_valid;
    if (!rst && ((psel && penable && pready && !pwrite) || vld_d)) begin
      got = vld_d ? {irms2_scaled, irms1_scaled} : prdata;
      samples_checked++;
      if (exp_q.size() == 0)
        miss(34'h0, got);
      else begin
        e = exp_q.pop_front();
        if ((!vld_d && e[32] !== pslverr) || (e[33] && e[31:0] !== got))
          miss(e, got);
      end
    end
  end

  function automatic logic [33:0] ex(input logic [15:0] v);
    return {2'b10, 16'h0, v};
  endfunction

  task automatic rd(input logic [11:0] a, input logic [33:0] n);
    exp_q.push_back(n);
    host_u.xfer(1'b0, a, 32'h0, rq);
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (g[k]) g[k] = `CAL_GAIN_RST;
  endtask

  task automatic cal(input logic [1:0] sel);
    logic [31:0] q[5];
    logic [4:0]  u;
    logic        ok;
    int          n;
    ok = 1'b1;
    for (int k = 0; k < 5; k++) begin
      u[k] = (chn[k] == 2) ? |sel : sel[chn[k]];
      q[k] = (x[3 + k] == 16'h0) ? 32'h0 : 32'(g[k]) * 32'(x[eidx[k]]) / 32'(x[3 + k]);
      // one selected gain out of window fails all
      if (u[k] && (q[k] < `CAL_GAIN_MIN || q[k] > `CAL_GAIN_MAX))
        ok = 1'b0;
    end
    host_u.gain_cmd(sel, x);
    // must be refused: the command is running
    host_u.xfer(1'b1, `CAL_GAIN_I1_OFF, 32'h1234, rq);
    host_u.xfer(1'b1, `CAL_CTRL_OFF, {29'h0, ~sel, 1'b1}, rq);
    n = 0;
    do begin
      rd(`CAL_STATUS_OFF, 34'h0);
      n++;
    end while (rq[0] !== 1'b0 && n < 100);
    if (rq[0] !== 1'b0) miss(34'h0, rq);
    rd(`CAL_STATUS_OFF, ex(ok ? 16'h0006 : 16'h000a));
    rd(`CAL_CTRL_OFF, ex({13'h0, sel, 1'b0}));
    for (int k = 0; k < 5; k++) begin
      if (ok && u[k])
        g[k] = q[k][15:0];
      rd(`CAL_GAIN_I1_OFF + 12'(4 * k), ex(g[k]));
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    irms_valid = 1'b0;
    meas_irms1 = 16'h0;
    meas_irms2 = 16'h0;
    failures = 0;
    samples_checked = 0;
    void'($urandom(32'h4b1e));
    do_reset();
    for (int k = 0; k < 5; k++)
      rd(`CAL_GAIN_I1_OFF + 12'(4 * k), ex(`CAL_GAIN_RST));
    rd(`CAL_RANGE_OFF, ex(16'h000c));
    rd(12'h048, 34'h1_0000_0000);
    rd(12'h006, 34'h1_0000_0000);
    x = '{16'h61a8, 16'hffff, 16'h9c40, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
    cal(2'b11);
    do_reset();
    x[0] = 16'h61a7;
    cal(2'b01);
    x = '{16'h8000, 16'hffff, 16'h8000, 16'h8000, 16'h8000, 16'h7fff, 16'h8000, 16'h8000};
    cal(2'b10);
    x[1] = 16'h8000;
    x[5] = 16'h8000;
    x[4] = 16'h0;
    cal(2'b10);
    x[0] = 16'h9000;
    x[2] = 16'ha000;
    x[4] = 16'h8000;
    cal(2'b01);
    repeat (4) begin
      for (int i = 0; i < 3; i++)
        x[i] = 16'(32'h03e8 + $urandom % 32'hc350);
      // readings near targets keep new gains mid-window
      for (int k = 0; k < 5; k++)
        x[3 + k] = x[eidx[k]] - x[eidx[k]] / 8 + 16'($urandom % (x[eidx[k]] / 4 + 1));
      cal(2'(1 + $urandom % 3));
    end
    // direct gain writes while idle, then used by the scaling below
    for (int k = 0; k < 2; k++) begin
      g[k] = 16'($urandom);
      host_u.xfer(1'b1, `CAL_GAIN_I1_OFF + 12'(4 * k), {16'h0, g[k]}, rq);
      rd(`CAL_GAIN_I1_OFF + 12'(4 * k), ex(g[k]));
    end
    // shifts kept at 16 and up so the product always fits
    for (int r = 16; r < 21; r++) begin
      host_u.xfer(1'b1, `CAL_RANGE_OFF, 32'(r), rq);
      x[0] = 16'($urandom);
      x[1] = 16'($urandom);
      meas_irms1 <= x[0];
      meas_irms2 <= x[1];
      irms_valid <= 1'b1;
      exp_q.push_back({2'b10, 16'((32'(g[1]) * x[1]) >> r), 16'((32'(g[0]) * x[0]) >> r)});
      @(posedge mclk);
      irms_valid <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    host_u.phase_adj(`CAL_PHASE1_OFF, 8'h10, 2.8);
    host_u.phase_adj(`CAL_PHASE2_OFF, 8'h00, 3.175);
    rd(`CAL_PHASE1_OFF, ex(16'h0080));
    rd(`CAL_PHASE2_OFF, ex(16'h007f));
    samples_checked++;
    if (phase_comp1 !== 8'sh80 || phase_comp2 !== 8'sh7f)
      miss({18'h0, phase_comp1, phase_comp2}, 32'h807f);
    end_sim();
  end

  initial begin
    #200000;
    failures++;
    end_sim();
  end
endmodule // power_monitor_gain_phase_calibration_tb

bind power_monitor_gain_phase_calibration cal_checker chk_u (.mclk(mclk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .irms_valid(irms_valid), .irms1_scaled(irms1_scaled),
  .phase_comp1(phase_comp1), .phase_comp2(phase_comp2), .cal_busy(cal_busy));
